//--- core/sic_i2c_slave.sv
// Serial slave transaction layer of the pressure sensor.
`timescale 1ns/10ps
module sic_i2c_slave (
   input wire logic clock,
   input wire logic resetn,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic [sic_pkg::SIC_RES_W-1:0] resultData,
   output logic cmdStrobe,
   output logic [7:0] cmdCode,
   output logic regWrEn,
   output logic [sic_pkg::SIC_REG_AW-1:0] regWrAddr,
   output logic [sic_pkg::SIC_DATA_W-1:0] regWrData
);
   typedef struct packed {
      logic scl1, scl2, sclPrev, sda1, sda2, sdaPrev;
      sic_pkg::sic_state_e state;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [2:0] byteIdx;
      logic rw;
      logic hostAck;
      sic_pkg::sic_mode_e mode;
      logic [5:0] regSel;
      logic [2:0] resCount;
      logic pendWrite;
      logic [7:0] cmd;
      logic [7:0] txShift;
      logic [47:0] snap;
      logic sdaLevel;
      logic sdaOeN;
      logic cmdStrobe;
      logic [7:0] cmdCode;
      logic regWrEn;
      logic [5:0] regWrAddr;
      logic [7:0] regWrData;
   } sic_slave_s;

   sic_slave_s st_reg;
   sic_slave_s st_next;
   logic [7:0] memRd;
   logic sclRise, sclFall, startSeen, stopSeen;

   // ------------------------------------------------------------------
   // Register store
   // ------------------------------------------------------------------
   sic_reg_mem #(.AW(sic_pkg::SIC_REG_AW), .DW(sic_pkg::SIC_DATA_W)) u_mem (
      .clock(clock),
      .resetn(resetn),
      .wrEn(st_reg.regWrEn),
      .wrAddr(st_reg.regWrAddr),
      .wrData(st_reg.regWrData),
      .rdAddr(st_reg.regSel),
      .rdData(memRd)
   );

   // ------------------------------------------------------------------
   // Link events
   // ------------------------------------------------------------------
   // Edges and bus conditions seen on the synchronised pins.
   assign sclRise = st_reg.scl2 & ~st_reg.sclPrev;
   assign sclFall = ~st_reg.scl2 & st_reg.sclPrev;
   assign startSeen = st_reg.scl2 & st_reg.sclPrev & st_reg.sdaPrev & ~st_reg.sda2;
   assign stopSeen = st_reg.scl2 & st_reg.sclPrev & ~st_reg.sdaPrev & st_reg.sda2;

   // ------------------------------------------------------------------
   // Transaction engine
   // ------------------------------------------------------------------
   // Walks the frame bit by bit and decides ack, data and side effects.
   always_comb begin
      st_next = st_reg;
      st_next.scl1 = sclIn;
      st_next.scl2 = st_reg.scl1;
      st_next.sclPrev = st_reg.scl2;
      st_next.sda1 = sdaIn;
      st_next.sda2 = st_reg.sda1;
      st_next.sdaPrev = st_reg.sda2;
      st_next.cmdStrobe = 1'b0;
      st_next.regWrEn = 1'b0;
      if (sclRise && st_reg.state != sic_pkg::SIC_RD_ACK) begin
         st_next.shift = {st_reg.shift[6:0], st_reg.sda2};
         st_next.bitCnt = st_reg.bitCnt + 4'h1;
      end
      if (startSeen) begin
         st_next.state = sic_pkg::SIC_ADDR;
         st_next.bitCnt = 4'h0;
         st_next.sdaOeN = 1'b1;
      end else if (stopSeen) begin
         st_next.state = sic_pkg::SIC_IDLE;
         st_next.sdaOeN = 1'b1;
      end else begin
         case (st_reg.state)
            sic_pkg::SIC_ADDR: begin
               if (sclFall && st_reg.bitCnt == sic_pkg::SIC_BITS_PER_BYTE) begin
                  if (st_reg.shift[7:1] == sic_pkg::SIC_SLAVE_ADDR7) begin
                     st_next.state = sic_pkg::SIC_ACK_ADDR;
                     st_next.sdaOeN = 1'b0;
                     st_next.rw = st_reg.shift[0];
                     st_next.snap = resultData;
                  end else begin
                     st_next.state = sic_pkg::SIC_IDLE;
                  end
               end
            end
            sic_pkg::SIC_ACK_ADDR: begin
               if (sclFall) begin
                  st_next.bitCnt = 4'h0;
                  st_next.byteIdx = 3'h0;
                  st_next.sdaOeN = 1'b1;
                  st_next.state = sic_pkg::SIC_WR_BYTE;
                  if (st_reg.rw) begin
                     // First returned byte: register word, first result byte, or fill when neither is selected.
                     st_next.state = sic_pkg::SIC_RD_BYTE;
                     st_next.txShift = sic_pkg::SIC_FILL_BYTE;
                     if (st_reg.mode == sic_pkg::SIC_MODE_REG) begin
                        st_next.txShift = memRd;
                     end else if (st_reg.mode == sic_pkg::SIC_MODE_RES && st_reg.resCount != 3'h0) begin
                        st_next.txShift = st_reg.snap[47:40];
                        st_next.snap = {st_reg.snap[39:0], 8'h00};
                     end
                     st_next.sdaOeN = st_next.txShift[7];
                     st_next.txShift = {st_next.txShift[6:0], 1'b1};
                     st_next.byteIdx = 3'h1;
                  end
               end
            end
            sic_pkg::SIC_WR_BYTE: begin
               if (sclFall && st_reg.bitCnt == sic_pkg::SIC_BITS_PER_BYTE) begin
                  st_next.state = sic_pkg::SIC_ACK_WR;
                  st_next.sdaOeN = 1'b0;
                  if (st_reg.byteIdx == 3'h0) begin
                     st_next.cmd = st_reg.shift;
                     st_next.pendWrite = 1'b0;
                     if (st_reg.shift[7:6] == sic_pkg::SIC_CMD_REG_WRITE) begin
                        st_next.pendWrite = 1'b1;
                     end else if (st_reg.shift[7:6] == sic_pkg::SIC_CMD_REG_READ) begin
                        st_next.mode = sic_pkg::SIC_MODE_REG;
                        st_next.regSel = st_reg.shift[5:0];
                     end else if (st_reg.shift == sic_pkg::SIC_CMD_RES_PT || st_reg.shift == sic_pkg::SIC_CMD_RES_AT) begin
                        st_next.mode = sic_pkg::SIC_MODE_RES;
                        st_next.resCount = sic_pkg::SIC_RES_LONG_BYTES;
                     end else if (st_reg.shift == sic_pkg::SIC_CMD_RES_P || st_reg.shift == sic_pkg::SIC_CMD_RES_A ||
                                  st_reg.shift == sic_pkg::SIC_CMD_RES_T) begin
                        st_next.mode = sic_pkg::SIC_MODE_RES;
                        st_next.resCount = sic_pkg::SIC_RES_SHORT_BYTES;
                     end else begin
                        st_next.cmdStrobe = 1'b1;
                        st_next.cmdCode = st_reg.shift;
                     end
                  end else if (st_reg.byteIdx == 3'h1 && st_reg.pendWrite) begin
                     st_next.regWrEn = 1'b1;
                     st_next.regWrAddr = st_reg.cmd[5:0];
                     st_next.regWrData = st_reg.shift;
                     st_next.pendWrite = 1'b0;
                  end else begin
                     // A byte beyond the transaction's shape is not acknowledged.
                     st_next.state = sic_pkg::SIC_IDLE;
                     st_next.sdaOeN = 1'b1;
                  end
                  st_next.byteIdx = st_reg.byteIdx + 3'h1;
               end
            end
            sic_pkg::SIC_ACK_WR: begin
               if (sclFall) begin
                  st_next.state = sic_pkg::SIC_WR_BYTE;
                  st_next.sdaOeN = 1'b1;
                  st_next.bitCnt = 4'h0;
               end
            end
            sic_pkg::SIC_RD_BYTE: begin
               if (sclFall) begin
                  if (st_reg.bitCnt == sic_pkg::SIC_BITS_PER_BYTE) begin
                     st_next.state = sic_pkg::SIC_RD_ACK;
                     st_next.sdaOeN = 1'b1;
                  end else begin
                     st_next.sdaOeN = st_reg.txShift[7];
                     st_next.txShift = {st_reg.txShift[6:0], 1'b1};
                  end
               end
            end
            sic_pkg::SIC_RD_ACK: begin
               if (sclRise) begin
                  st_next.hostAck = ~st_reg.sda2;
               end
               if (sclFall) begin
                  st_next.bitCnt = 4'h0;
                  if (st_reg.hostAck) begin
                     // Next byte: results until the count is used up, then fill.
                     st_next.state = sic_pkg::SIC_RD_BYTE;
                     st_next.txShift = sic_pkg::SIC_FILL_BYTE;
                     if (st_reg.mode == sic_pkg::SIC_MODE_RES && st_reg.byteIdx < st_reg.resCount) begin
                        st_next.txShift = st_reg.snap[47:40];
                        st_next.snap = {st_reg.snap[39:0], 8'h00};
                     end
                     st_next.sdaOeN = st_next.txShift[7];
                     st_next.txShift = {st_next.txShift[6:0], 1'b1};
                     st_next.byteIdx = st_reg.byteIdx + 3'h1;
                  end else begin
                     st_next.state = sic_pkg::SIC_IDLE;
                  end
               end
            end
            default: begin
               st_next.sdaOeN = 1'b1;
            end
         endcase
      end
   end

   // Registers the whole engine; pins idle high after reset.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.scl1 <= 1'b1;
         st_reg.scl2 <= 1'b1;
         st_reg.sclPrev <= 1'b1;
         st_reg.sda1 <= 1'b1;
         st_reg.sda2 <= 1'b1;
         st_reg.sdaPrev <= 1'b1;
         st_reg.state <= sic_pkg::SIC_IDLE;
         st_reg.mode <= sic_pkg::SIC_MODE_NONE;
         st_reg.sdaOeN <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sdaOut = st_reg.sdaLevel;
   assign sdaOeN = st_reg.sdaOeN;
   assign cmdStrobe = st_reg.cmdStrobe;
   assign cmdCode = st_reg.cmdCode;
   assign regWrEn = st_reg.regWrEn;
   assign regWrAddr = st_reg.regWrAddr;
   assign regWrData = st_reg.regWrData;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_addr_match: assert property (@(posedge clock) disable iff (!resetn)
      $rose(st_reg.state == sic_pkg::SIC_ACK_ADDR) |-> st_reg.shift[7:1] == sic_pkg::SIC_SLAVE_ADDR7 && !st_reg.sdaOeN)
      else $error("Address acknowledged for a foreign address.");
   a_write_cmd: assert property (@(posedge clock) disable iff (!resetn)
      st_reg.regWrEn |-> st_reg.cmd[7:6] == sic_pkg::SIC_CMD_REG_WRITE && st_reg.regWrAddr == st_reg.cmd[5:0])
      else $error("Register written without a register-write command.");
   a_read_select: assert property (@(posedge clock) disable iff (!resetn)
      (sclFall && st_reg.state == sic_pkg::SIC_WR_BYTE && st_reg.bitCnt == sic_pkg::SIC_BITS_PER_BYTE
       && st_reg.byteIdx == 3'h0 && st_reg.shift[7:6] == sic_pkg::SIC_CMD_REG_READ && !startSeen && !stopSeen)
      |=> st_reg.mode == sic_pkg::SIC_MODE_REG && st_reg.regSel == $past(st_reg.shift[5:0]))
      else $error("Register-read command did not select its register.");
   a_read_bit: assert property (@(posedge clock) disable iff (!resetn)
      $rose(st_reg.state == sic_pkg::SIC_RD_BYTE) |-> st_reg.rw)
      else $error("Sensor drove data in a write frame.");
   a_long_count: assert property (@(posedge clock) disable iff (!resetn)
      (sclFall && st_reg.state == sic_pkg::SIC_WR_BYTE && st_reg.bitCnt == sic_pkg::SIC_BITS_PER_BYTE
       && st_reg.byteIdx == 3'h0 && !startSeen && !stopSeen
       && (st_reg.shift == sic_pkg::SIC_CMD_RES_PT || st_reg.shift == sic_pkg::SIC_CMD_RES_AT))
      |=> st_reg.resCount == sic_pkg::SIC_RES_LONG_BYTES)
      else $error("Six-byte result command set the wrong count.");
   a_short_count: assert property (@(posedge clock) disable iff (!resetn)
      (sclFall && st_reg.state == sic_pkg::SIC_WR_BYTE && st_reg.bitCnt == sic_pkg::SIC_BITS_PER_BYTE
       && st_reg.byteIdx == 3'h0 && !startSeen && !stopSeen
       && (st_reg.shift == sic_pkg::SIC_CMD_RES_P || st_reg.shift == sic_pkg::SIC_CMD_RES_A
       || st_reg.shift == sic_pkg::SIC_CMD_RES_T))
      |=> st_reg.resCount == sic_pkg::SIC_RES_SHORT_BYTES)
      else $error("Three-byte result command set the wrong count.");
   a_write_decode: assert property (@(posedge clock) disable iff (!resetn)
      (sclFall && st_reg.state == sic_pkg::SIC_WR_BYTE && st_reg.bitCnt == sic_pkg::SIC_BITS_PER_BYTE
       && st_reg.byteIdx == 3'h0 && st_reg.shift[7:6] == sic_pkg::SIC_CMD_REG_WRITE && !startSeen && !stopSeen)
      |=> st_reg.pendWrite && !st_reg.cmdStrobe)
      else $error("Register-write command not recognised.");
   a_msb_first: assert property (@(posedge clock) disable iff (!resetn)
      (sclFall && st_reg.state == sic_pkg::SIC_RD_BYTE && st_reg.bitCnt < sic_pkg::SIC_BITS_PER_BYTE
       && !startSeen && !stopSeen)
      |=> st_reg.sdaOeN == $past(st_reg.txShift[7]))
      else $error("Returned bit not taken from the top of the byte.");
   a_idle_release: assert property (@(posedge clock) disable iff (!resetn)
      st_reg.state == sic_pkg::SIC_IDLE |-> ##1 st_reg.sdaOeN)
      else $error("Data line held while the slave is idle.");
endmodule

//--- core/sic_pkg.sv
// Shared constants and types for the sensor serial command slave.
package sic_pkg;
   // -----------------------------------------------------------------
   // Link addressing and command encodings
   // -----------------------------------------------------------------
   localparam logic [6:0] SIC_SLAVE_ADDR7 = 7'h76;
   localparam logic [1:0] SIC_CMD_REG_READ = 2'h2;
   localparam logic [1:0] SIC_CMD_REG_WRITE = 2'h3;
   localparam logic [7:0] SIC_CMD_RES_PT = 8'h10;
   localparam logic [7:0] SIC_CMD_RES_AT = 8'h11;
   localparam logic [7:0] SIC_CMD_RES_P = 8'h30;
   localparam logic [7:0] SIC_CMD_RES_A = 8'h31;
   localparam logic [7:0] SIC_CMD_RES_T = 8'h32;
   localparam logic [2:0] SIC_RES_SHORT_BYTES = 3'h3;
   localparam logic [2:0] SIC_RES_LONG_BYTES = 3'h6;
   localparam logic [7:0] SIC_FILL_BYTE = 8'hff;
   localparam logic [3:0] SIC_BITS_PER_BYTE = 4'h8;
   localparam int SIC_REG_AW = 6;
   localparam int SIC_DATA_W = 8;
   localparam int SIC_RES_W = 48;

   // -----------------------------------------------------------------
   // Enumerations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SIC_MODE_NONE = 2'h0,
      SIC_MODE_REG = 2'h1,
      SIC_MODE_RES = 2'h2
   } sic_mode_e;

   typedef enum logic [6:0] {
      SIC_IDLE = 7'h01,
      SIC_ADDR = 7'h02,
      SIC_ACK_ADDR = 7'h04,
      SIC_WR_BYTE = 7'h08,
      SIC_ACK_WR = 7'h10,
      SIC_RD_BYTE = 7'h20,
      SIC_RD_ACK = 7'h40
   } sic_state_e;
endpackage

//--- core/sic_reg_mem.sv
// Control register store with one write port and a registered read port.
`timescale 1ns/10ps
module sic_reg_mem #(
   parameter int AW = 6,
   parameter int DW = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0] rdData
);
   typedef struct packed {
      logic [(1<<AW)-1:0][DW-1:0] mem;
      logic [DW-1:0] rd;
   } sic_mem_s;

   sic_mem_s st_reg;
   sic_mem_s st_next;

   // Refuses, while the design is built, widths that leave the store without words or bits.
   if (AW < 1 || DW < 1) begin : g_bad_width
      $error("Register store needs nonzero widths.");
   end

   // Stores a written word and registers the addressed word for reading.
   always_comb begin
      st_next = st_reg;
      if (wrEn) begin
         st_next.mem[wrAddr] = wrData;
      end
      st_next.rd = st_reg.mem[rdAddr];
   end

   // Clears the store at reset.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdData = st_reg.rd;
endmodule

//--- dv/sic_host_model.sv
// Behavioural serial bus host that drives the link for the bench.
`timescale 1ns/10ps
module sic_host_model (
   output logic scl,
   output logic sdaOeN,
   input wire logic sda
);
   // Both lines start released, so the pull-up holds them high.
   initial begin
      scl = 1'b1;
      sdaOeN = 1'b1;
   end

   // Start condition: data falls while the clock stays high.
   task automatic start_bit();
      #16 sdaOeN = 1'b1;
      #16 scl = 1'b1;
      #16 sdaOeN = 1'b0;
      #16 scl = 1'b0;
   endtask

   // Stop condition: data rises while the clock stays high.
   task automatic stop_bit();
      #16 sdaOeN = 1'b0;
      #16 scl = 1'b1;
      #16 sdaOeN = 1'b1;
      #16;
   endtask

   // One bit slot; the host changes data only while the clock is low.
   task automatic bit_slot(input logic tx, output logic rx);
      #16 sdaOeN = tx;
      #16 scl = 1'b1;
      #28 rx = sda;
      #4 scl = 1'b0;
   endtask

   // Sends a byte and returns whether the sensor pulled the ninth bit low.
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], r);
      end
      bit_slot(1'b1, r);
      ack = ~r;
   endtask

   // Receives a byte; the last byte of a frame is answered with a nack.
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, r);
         b[i] = r;
      end
      bit_slot(last, r);
   endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the sensor serial command slave.
`timescale 1ns/10ps
module testbench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [47:0] resultData = 48'h0;
   wire logic scl, hostOeN, sdaOut, sdaOeN, sdaBus, cmdStrobe, regWrEn;
   wire logic [7:0] cmdCode, regWrData;
   wire logic [5:0] regWrAddr;
   int mismatches = 0;
   int checks = 0;
   int seed = 53;
   int wrSeen = 0;
   int cmdSeen = 0;
   logic [7:0] lastCmd;
   logic [13:0] lastWr;
   logic [7:0] cmds [5] = '{8'h10, 8'h11, 8'h30, 8'h31, 8'h32};

   // Wired-AND data line with a pull-up.
   assign sdaBus = hostOeN & (sdaOeN | sdaOut);

   // Clock of 5 ns.
   always #2.5 clock = ~clock;

   sic_host_model host_u (.scl(scl), .sdaOeN(hostOeN), .sda(sdaBus));
   sic_i2c_slave dut_u (.clock(clock), .resetn(resetn), .sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .resultData(resultData), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
      .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData));

   // Counts the one-cycle pulses and keeps what they carried.
   always @(posedge clock) begin
      if (regWrEn === 1'b1) begin
         wrSeen++;
         lastWr = {regWrAddr, regWrData};
      end
      if (cmdStrobe === 1'b1) begin
         cmdSeen++;
         lastCmd = cmdCode;
      end
   end

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Expected read bytes: six whole, three from the top, then fill.
   function automatic logic [47:0] res_expect(input logic [47:0] r, input int n);
      res_expect = (n == 6) ? r : (n == 3) ? {24'h0, r[47:24]} : {16'h0, r[47:24], 8'hff};
   endfunction

   // ----------------------------------------
   // Frames
   // ----------------------------------------
   // Write frame of n bytes; acks come back with the first byte lowest.
   task automatic wr_frame(input logic [23:0] bytes, input int n, output logic [2:0] acks);
      logic k;
      acks = 3'h0;
      host_u.start_bit();
      for (int i = 0; i < n; i++) begin
         host_u.send_byte(bytes[23-8*i -: 8], k);
         acks[i] = k;
      end
      host_u.stop_bit();
   endtask

   // Read frame of n bytes, gathered first byte highest.
   task automatic rd_frame(input int n, output logic [47:0] got, output logic ack);
      logic [7:0] b;
      got = 48'h0;
      host_u.start_bit();
      host_u.send_byte(8'hed, ack);
      for (int i = 0; i < n && ack; i++) begin
         host_u.recv_byte(i == n - 1, b);
         got = {got[39:0], b};
      end
      host_u.stop_bit();
   endtask

   // Main sequence.
   initial begin
      logic [2:0] acks;
      logic [47:0] got;
      logic ack;
      logic [5:0] ra;
      logic [7:0] rd;
      int w0;
      int n;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      repeat (6) @(posedge clock);
      // With no read command since reset, a read frame returns the fill byte.
      rd_frame(1, got, ack);
      check("read addr ack", ack, 1'b1);
      check("read before cmd", got, 8'hff);
      // Register writes and read-backs, edge addresses first.
      for (int i = 0; i < 8; i++) begin
         ra = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
         rd = 8'($random(seed));
         w0 = wrSeen;
         wr_frame({8'hec, 2'h3, ra, rd}, 3, acks);
         check("write acks", acks, 3'h7);
         check("write pulses", wrSeen - w0, 1);
         check("write fields", lastWr, {ra, rd});
         wr_frame({8'hec, 2'h2, ra, 8'h00}, 2, acks);
         check("read cmd acks", acks, 3'h3);
         rd_frame(1, got, ack);
         check("read data", got, rd);
      end
      // Every result command; the last one reads one byte past the end.
      for (int i = 0; i < 5; i++) begin
         @(posedge clock);
         resultData <= 48'({$random(seed), $random(seed)});
         n = (i < 2) ? 6 : 3;
         wr_frame({8'hec, cmds[i], 8'h00}, 2, acks);
         check("result cmd acks", acks, 3'h3);
         rd_frame(n + (i == 4), got, ack);
         check("result bytes", got, res_expect(resultData, n + (i == 4)));
      end
      // A data byte after a plain or a register-read command is refused.
      w0 = cmdSeen;
      wr_frame({8'hec, 8'h06, 8'h5a}, 3, acks);
      check("plain cmd acks", acks, 3'h3);
      check("cmd pulses", cmdSeen - w0, 1);
      check("cmd code", lastCmd, 8'h06);
      w0 = wrSeen;
      wr_frame({8'hec, 8'h85, 8'h11}, 3, acks);
      check("read cmd data acks", acks, 3'h3);
      check("no write pulse", wrSeen - w0, 0);
      // A reset in mid-run clears the store and the read selection.
      @(posedge clock);
      resetn <= 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      repeat (6) @(posedge clock);
      rd_frame(1, got, ack);
      check("read after reset", got, 8'hff);
      wr_frame({8'hec, 2'h2, ra, 8'h00}, 2, acks);
      check("read cmd acks", acks, 3'h3);
      rd_frame(1, got, ack);
      check("cleared register", got, 8'h00);
      // Foreign and bit-reversed addresses get no ack.
      for (int i = 0; i < 3; i++) begin
         wr_frame({(i == 0) ? 8'hee : (i == 1) ? 8'h37 : 8'h6c, 16'h0}, 1, acks);
         check("foreign addr ack", acks, 3'h0);
      end
      tally_and_finish();
   end

   // Watchdog at about three times the expected run of some 14000 cycles.
   initial begin
      #200000;
      mismatches++;
      tally_and_finish();
   end
endmodule
